// ---- rtl/hscp_params.svh ----
// constants of the host serial control port
`ifndef HSCP_PARAMS_SVH
`define HSCP_PARAMS_SVH
`define HSCP_BYTE_BITS 8
`define HSCP_MAX_CMD_BYTES 2
`define HSCP_CORE_PERIOD_PS 5000
`define HSCP_HIZ_MAX_NS 1000
`define HSCP_HIZ_CYCLES ((`HSCP_HIZ_MAX_NS * 1000) / `HSCP_CORE_PERIOD_PS)
`define HSCP_REPLY_RESET 8'h00
`endif

// ---- rtl/hscp_pkg.sv ----
// types of the host serial control port
package hscp_pkg;
   typedef logic [7:0] hscp_byte_t;
   typedef enum logic [1:0] {
      HSCP_IDLE,
      HSCP_BUSY,
      HSCP_DONE
   } hscp_state_e;
endpackage

// ---- rtl/hscp_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module hscp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // data
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] stage1;
   initial begin
      if (WIDTH < 1) begin
         $error("width must be at least one");
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= '0;
         o_q <= '0;
      end else begin
         stage1 <= i_d;
         o_q <= stage1;
      end
   end
endmodule

// ---- rtl/hscp_shift.sv ----
// serial shifter on the link clock, framed by chip select
`timescale 1ns/1ps
module hscp_shift #(
   parameter int BITS = 8,
   parameter int MAX_BYTES = 2
) (
   // link clock and frame
   input wire logic i_sclk,
   input wire logic i_sel,
   // serial lines
   input wire logic i_cmd_bit,
   output logic o_reply_bit,
   // command and reply words
   input wire logic [BITS-1:0] i_reply,
   output logic [BITS*MAX_BYTES-1:0] o_cmd,
   output logic [1:0] o_nbytes
);
   logic [$clog2(BITS)-1:0] bit_cnt;
   logic [BITS-2:0] byte_sr;
   wire [BITS-1:0] byte_next = {byte_sr, i_cmd_bit};
   wire [BITS*(MAX_BYTES+1)-1:0] cmd_next = {o_cmd, byte_next};
   wire last_bit = (bit_cnt == $clog2(BITS)'(BITS - 1));
   initial begin
      if (MAX_BYTES < 1 || MAX_BYTES > 3 || BITS < 2) begin
         $error("unsupported shifter size");
      end
   end
   // ------------------------------------------------
   // capture
   // ------------------------------------------------
   // the link clock may stop outside frames, so deselect clears asynchronously
   always_ff @(posedge i_sclk or negedge i_sel) begin
      if (!i_sel) begin
         bit_cnt <= '0;
         o_nbytes <= '0;
         o_cmd <= '0;
         byte_sr <= '0;
      end else begin
         // only whole bytes reach the word, a cut byte is dropped
         byte_sr <= byte_next[BITS-2:0];
         if (last_bit) begin
            o_cmd <= cmd_next[BITS*MAX_BYTES-1:0];
         end
         bit_cnt <= last_bit ? '0 : bit_cnt + 1'b1;
         if (last_bit && o_nbytes != 2'(MAX_BYTES)) begin
            o_nbytes <= o_nbytes + 2'd1;
         end
      end
   end
   // ------------------------------------------------
   // reply, msb first, picked by the bit counter
   // ------------------------------------------------
   // no falling-edge shifter: bit 7 must stand before the first rising edge
   // whichever level the clock idles at; the core keeps the byte steady
   // while selected, and the bit goes back to the core through a synchroniser
   assign o_reply_bit = i_reply[(BITS-1) - int'(bit_cnt)];
endmodule

// ---- rtl/hscp_top.sv ----
// host serial control port, device side
`timescale 1ns/1ps
`include "hscp_params.svh"
// What this block does
// - reply bytes shifted out msb first
// - command bits sampled on rising serial clock
// - command executes when chip select rises
// - serial clock may idle high or low
// - reply driven from the first serial clock low phase of a frame, released within three core cycles of deselect
module hscp_top #(
   parameter int HIZ_CYCLES = `HSCP_HIZ_CYCLES
) (
   // core clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   // serial link
   input wire logic I_SERIAL_CLK,
   input wire logic I_CHIP_SELECT_LOW_N,
   input wire logic I_CMD_DATA,
   output logic O_REPLY_OUTPUT_LINE,
   output logic O_REPLY_OUTPUT_LINE_OE,
   // core side
   input wire logic [7:0] I_REPLY_BYTE,
   output logic [15:0] O_CMD_WORD,
   output logic [1:0] O_CMD_BYTES,
   output logic O_CMD_STROBE
);
   logic rst_s1;
   logic rst_n;
   logic [15:0] cmd_link;
   logic [1:0] nbytes_link;
   logic reply_bit_link;
   logic sel_sync;
   logic sel_prev;
   logic [17:0] word_mid;
   logic [17:0] word_late;
   logic sclk_low_sync;
   hscp_pkg::hscp_state_e state;
   hscp_pkg::hscp_state_e next_state;
   initial begin
      if (HIZ_CYCLES < 1) begin
         $error("release delay must be at least one cycle");
      end
   end
   // ------------------------------------------------
   // reset release
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end
   // ------------------------------------------------
   // link side; only edges inside a frame matter, so idle level is free
   // ------------------------------------------------
   wire sel_link = ~I_CHIP_SELECT_LOW_N;
   hscp_shift #(
      .BITS(`HSCP_BYTE_BITS),
      .MAX_BYTES(`HSCP_MAX_CMD_BYTES)
   ) u_shift (
      .i_sclk(I_SERIAL_CLK),
      .i_sel(sel_link),
      .i_cmd_bit(I_CMD_DATA),
      .o_reply_bit(reply_bit_link),
      .i_reply(I_REPLY_BYTE),
      .o_cmd(cmd_link),
      .o_nbytes(nbytes_link)
   );
   // ------------------------------------------------
   // crossing: chip select and the link word into the core clock
   // ------------------------------------------------
   hscp_sync #(.WIDTH(1)) u_sel_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_n),
      .i_d(sel_link),
      .o_q(sel_sync)
   );
   wire frame_end = sel_prev & ~sel_sync;
   wire frame_start = ~sel_prev & sel_sync;
   // the link word is still for at least 100 ns before deselect, which then
   // clears it; four stages let frame_end pick a copy taken before the clear
   hscp_sync #(.WIDTH(18)) u_word_sync_a (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_n),
      .i_d({nbytes_link, cmd_link}),
      .o_q(word_mid)
   );
   hscp_sync #(.WIDTH(18)) u_word_sync_b (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_n),
      .i_d(word_mid),
      .o_q(word_late)
   );
   wire [15:0] word_seen = word_late[15:0];
   wire [1:0] bytes_seen = word_late[17:16];
   wire take_cmd = frame_end && (state == hscp_pkg::HSCP_BUSY) && (bytes_seen != 2'b00);
   always_comb begin
      next_state = state;
      unique case (state)
         hscp_pkg::HSCP_IDLE: if (frame_start) next_state = hscp_pkg::HSCP_BUSY;
         hscp_pkg::HSCP_BUSY: if (frame_end) next_state = hscp_pkg::HSCP_DONE;
         hscp_pkg::HSCP_DONE: next_state = hscp_pkg::HSCP_IDLE;
      endcase
   end
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= hscp_pkg::HSCP_IDLE;
         sel_prev <= 1'b0;
      end else begin
         state <= next_state;
         sel_prev <= sel_sync;
      end
   end
   // ------------------------------------------------
   // command hand-off at end of frame
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_CMD_WORD <= 16'h0000;
         O_CMD_BYTES <= 2'b00;
         O_CMD_STROBE <= 1'b0;
      end else begin
         // an empty frame leaves the last command standing
         O_CMD_STROBE <= take_cmd;
         if (take_cmd) begin
            O_CMD_WORD <= word_seen;
            O_CMD_BYTES <= bytes_seen;
         end
      end
   end
   // ------------------------------------------------
   // reply output and enable
   // ------------------------------------------------
   // enable waits for a clock low phase inside the frame and drops within
   // three core cycles of deselect, far inside HIZ_CYCLES
   hscp_sync #(.WIDTH(1)) u_sclk_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_n),
      .i_d(~I_SERIAL_CLK),
      .o_q(sclk_low_sync)
   );
   wire next_oe = sel_sync && (O_REPLY_OUTPUT_LINE_OE || sclk_low_sync);
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_REPLY_OUTPUT_LINE_OE <= 1'b0;
      end else begin
         O_REPLY_OUTPUT_LINE_OE <= next_oe;
      end
   end
   // reply data passes through the core clock for a registered output
   hscp_sync #(.WIDTH(1)) u_reply_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_n),
      .i_d(reply_bit_link),
      .o_q(O_REPLY_OUTPUT_LINE)
   );
endmodule

// ---- bench/hscp_top_props.sv ----
// assertions on the ports of the host serial control port
`timescale 1ns/1ps
module hscp_top_props #(
   parameter int HIZ_CYCLES = 200
) (
   // watched ports
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   input wire logic I_CHIP_SELECT_LOW_N,
   input wire logic O_REPLY_OUTPUT_LINE_OE,
   input wire logic [15:0] O_CMD_WORD,
   input wire logic [1:0] O_CMD_BYTES,
   input wire logic O_CMD_STROBE
);
   wire sel_n = I_CHIP_SELECT_LOW_N;
   wire oe = O_REPLY_OUTPUT_LINE_OE;
   wire stb = O_CMD_STROBE;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RSTN);
   property p_hiz; $rose(sel_n) |-> ##[1:HIZ_CYCLES] !oe; endproperty
   a_hiz: assert property (p_hiz) else $error("reply line not released");
   property p_oe_sel; $rose(oe) |-> !$past(sel_n, 2); endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("reply driven unselected");
   property p_late; stb |-> sel_n && $past(sel_n, 3); endproperty
   a_late: assert property (p_late) else $error("command before deselect");
   property p_pulse; stb |=> !stb; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe too long");
   property p_whole; stb |-> O_CMD_BYTES inside {2'h1, 2'h2}; endproperty
   a_whole: assert property (p_whole) else $error("bad byte count");
   property p_hold; sel_n && $past(sel_n, 8) && !stb |-> $stable({O_CMD_WORD, O_CMD_BYTES}); endproperty
   a_hold: assert property (p_hold) else $error("command moved while idle");
   property p_idle_off; sel_n && $past(sel_n, 4) |-> !oe; endproperty
   a_idle_off: assert property (p_idle_off) else $error("reply driven while idle");
   c_two: cover property (stb && O_CMD_BYTES == 2'h2);
   c_one: cover property (stb && O_CMD_BYTES == 2'h1);
   c_rel: cover property ($fell(oe));
endmodule
bind hscp_top hscp_top_props #(.HIZ_CYCLES(HIZ_CYCLES)) hscp_top_props_i (.I_CORE_CLK(I_CORE_CLK),
   .I_RSTN(I_RSTN), .I_CHIP_SELECT_LOW_N(I_CHIP_SELECT_LOW_N), .O_REPLY_OUTPUT_LINE_OE(O_REPLY_OUTPUT_LINE_OE),
   .O_CMD_WORD(O_CMD_WORD), .O_CMD_BYTES(O_CMD_BYTES), .O_CMD_STROBE(O_CMD_STROBE));

// ---- bench/hscp_host_model.sv ----
// host master model on the serial control link
`timescale 1ns/1ps
module hscp_host_model (
   // serial link
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // clock idles at either level; reply taken on the rising edge
   task automatic frame(input logic [15:0] w, input int n, input logic idle, output logic [7:0] rx);
      o_sclk = idle;
      #200 o_cs_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_mosi = w[i];
         #32 o_sclk = 1'b1;
         rx = {rx[6:0], i_miso};
         #32;
      end
      o_sclk = idle;
      o_mosi = ~o_mosi;
      #100 o_cs_n = 1'b1;
      #1100;
   endtask
endmodule

// ---- bench/tb_hscp_top.sv ----
// testbench of the host serial control port
`timescale 1ns/1ps
module tb_hscp_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reply = 8'h00;
   logic sclk, cs_n, mosi, rdata, oe, stb;
   logic [15:0] word, got_word;
   logic [1:0] bytes, got_bytes;
   logic [7:0] rx;
   int n_errors = 0;
   int checked = 0;
   int n_stb = 0;
   // no pull on the reply line: released, it reads inverted, so a late enable shows
   wire rline = oe ? rdata : ~rdata;
   initial begin
      forever #2.5 clk = ~clk;
   end
   hscp_top hscp_top_i (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_SERIAL_CLK(sclk), .I_CHIP_SELECT_LOW_N(cs_n),
      .I_CMD_DATA(mosi), .O_REPLY_OUTPUT_LINE(rdata), .O_REPLY_OUTPUT_LINE_OE(oe), .I_REPLY_BYTE(reply),
      .O_CMD_WORD(word), .O_CMD_BYTES(bytes), .O_CMD_STROBE(stb));
   hscp_host_model hscp_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(rline));
   always @(posedge clk) begin
      if (stb === 1'b1) begin
         n_stb <= n_stb + 1;
         got_word <= word;
         got_bytes <= bytes;
      end
   end
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_two_byte;
      int s = n_stb;
      @(negedge clk) reply = 8'h96;
      hscp_host_model_i.frame(16'ha53c, 16, 1'b1, rx);
      chk("strobes", 16'(n_stb - s), 16'h0001);
      chk("word", got_word, 16'ha53c);
      chk("bytes", {14'h0000, got_bytes}, 16'h0002);
      chk("reply", {8'h00, rx}, 16'h0096);
   endtask
   task automatic t_one_byte;
      int s = n_stb;
      @(negedge clk) reply = 8'h3c;
      hscp_host_model_i.frame(16'h005a, 8, 1'b0, rx);
      chk("strobes", 16'(n_stb - s), 16'h0001);
      chk("word", {8'h00, got_word[7:0]}, 16'h005a);
      chk("bytes", {14'h0000, got_bytes}, 16'h0001);
      chk("reply", {8'h00, rx}, 16'h003c);
   endtask
   task automatic t_partial;
      hscp_host_model_i.frame(16'h0a5f, 12, 1'b1, rx);
      chk("word", {8'h00, got_word[7:0]}, 16'h00a5);
      chk("bytes", {14'h0000, got_bytes}, 16'h0001);
      hscp_host_model_i.frame(16'h00c3, 8, 1'b1, rx);
      chk("word", {8'h00, got_word[7:0]}, 16'h00c3);
   endtask
   task automatic t_empty;
      int s = n_stb;
      hscp_host_model_i.frame(16'h0005, 4, 1'b0, rx);
      chk("strobes", 16'(n_stb - s), 16'h0000);
      chk("oe", {15'h0000, oe}, 16'h0000);
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      t_two_byte;
      t_one_byte;
      t_partial;
      t_empty;
      results;
   end
   initial begin
      #40000;
      n_errors++;
      results;
   end
endmodule
